// >>> pvt_pkg.sv
// shared constants, state codes and carrier structs for the profile mode logic
`default_nettype none
package pvt_pkg;

  // ---------------------------------------------------------------
  // mode codes and bit positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  MODE_PROF_VEL  = 8'h03;
  localparam logic [7:0]  MODE_PROF_TRQ  = 8'h04;
  localparam int          CTRL_HALT_BIT  = 8;
  localparam int          ST_TARGET_BIT  = 10;
  localparam int          ST_LIMIT_BIT   = 11;
  localparam int          ST_ZERO_BIT    = 12;
  localparam int          ST_DEV_BIT     = 13;
  localparam int          POL_VEL_BIT    = 6;
  localparam int          SUBMODE_BIT    = 5;
  localparam logic [15:0] PROFILE_TRAP   = 16'h0000;
  localparam logic [15:0] PROFILE_JERK   = 16'h0003;
  localparam logic [15:0] STATUS_RESET   = 16'h1000;

  // ---------------------------------------------------------------
  // timing: control tick derived from the system clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC  = 1000000000 / TICK_PERIOD_NS;
  localparam int TIMER_W        = 17;
  localparam int NUM_TIMERS     = 4;

  // ---------------------------------------------------------------
  // mode state, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_VEL  = 3'b010,
    ST_TRQ  = 3'b100
  } mode_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic signed [31:0] target;
    logic [31:0]        maxProfile;
    logic [31:0]        maxMotor;
    logic [31:0]        accel;
    logic [31:0]        decel;
    logic [31:0]        jerk;
    logic [15:0]        profileType;
    logic [7:0]         polarity;
    logic [31:0]        window;
    logic [15:0]        windowTime;
    logic [31:0]        threshold;
    logic [15:0]        thresholdTime;
    logic [31:0]        maxSlip;
    logic [15:0]        slipTimeout;
  } vel_cfg_t;

  typedef struct packed {
    logic signed [15:0] target;
    logic [15:0]        maxTorque;
    logic [15:0]        maxCurrent;
    logic [15:0]        motorMaxCurrent;
    logic [31:0]        slope;
    logic [15:0]        window;
    logic [15:0]        windowTime;
    logic [31:0]        submode;
  } trq_cfg_t;

  typedef struct packed {
    logic signed [31:0] velActual;
    logic signed [15:0] trqActual;
    logic signed [31:0] slipError;
  } feedback_t;

endpackage
`default_nettype wire

// >>> profile_velocity_torque_modes.sv
// velocity profile and torque profile mode logic of the drive controller
// Overview of operation
// - Mode code 3 in the selector runs the velocity profile mode.
// - Mode code 4 in the selector runs the torque profile mode.
// - Velocity mode: halt stops motor; falling edge ramps up, rising brakes.
// - Velocity mode bit 10: reached/in window, or braking/zero speed under halt.
// - Speed reached only after staying inside the window for window time.
// - Bit 12 clears once speed exceeded threshold for threshold time.
// - Closed loop: bit 13 set when slippage exceeds limit beyond timeout.
// - Polarity bit 6 inverts the sign of the target speed.
// - Ramp shape 0 trapezoidal, 3 jerk-limited; jerk only applied for 3.
// - Speed capped at smaller of profile and motor maximum speed.
// - Ramp output is both speed demand and speed controller setpoint.
// - Operation enabled in velocity mode ramps to target within limits.
// - Torque mode runs only while closed loop control is active.
// - Torque mode: halt stops motor; falling edge starts, rising stops.
// - Torque reached only after staying in band for window time.
// - Torque mode bit 10: torque reached, or braking/zero speed under halt.
// - Torque mode bit 11 set when target torque exceeds max torque.
// - Torque quantities are in thousandths of rated torque.
// - Target torque limited to smaller of max current and max torque.
// - Torque ramp slope limited per second; ramp output is torque demand.
// - Values above rated torque allowed but capped at motor max current.
// - Submode bit 5 zero: speed cap and field weakening; one: neither.
`timescale 1ns/1ns
`default_nettype none
module profile_velocity_torque_modes #(
  parameter int TICK_CYCLES = pvt_pkg::TICK_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       operating_mode_selector,
  input  wire logic [15:0]      ctrlWord,
  input  wire logic             opEnabled,
  input  wire logic             closedLoop,
  input  wire pvt_pkg::vel_cfg_t velCfg,
  input  wire pvt_pkg::trq_cfg_t trqCfg,
  input  wire pvt_pkg::feedback_t fb,
  output logic [15:0]           statusWord,
  output logic signed [31:0]    velDemand,
  output logic signed [31:0]    velSetpoint,
  output logic signed [31:0]    torqueDemand,
  output logic                  speedCapEn,
  output logic                  fieldWeakEn
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] absS(input logic signed [31:0] v);
    absS = v[31] ? 32'(-v) : 32'(v);
  endfunction
  function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
    min32 = (a < b) ? a : b;
  endfunction
  // ---------------------------------------------------------------
  // control tick divider
  // ---------------------------------------------------------------
  logic [31:0] tickCnt_q;
  logic [31:0] tickCnt_d;
  logic        tick_q;
  logic        tick_d;
  // one tick pulse every TICK_CYCLES clocks
  always_comb begin
    tick_d    = 1'b0;
    tickCnt_d = tickCnt_q + 32'h0000_0001;
    if (tickCnt_q >= 32'(TICK_CYCLES - 1)) begin
      tickCnt_d = 32'h0000_0000;
      tick_d    = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tickCnt_q <= 32'h0000_0000;
      tick_q    <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      tick_q    <= tick_d;
    end
  end
  // ---------------------------------------------------------------
  // mode selection
  // ---------------------------------------------------------------
  pvt_pkg::mode_state_t stateQ;
  pvt_pkg::mode_state_t stateD;
  logic                 halt;
  assign halt = ctrlWord[pvt_pkg::CTRL_HALT_BIT];
  // leaving operation enabled drops straight to idle
  always_comb begin
    stateD = pvt_pkg::ST_IDLE;
    if (opEnabled) begin
      if (operating_mode_selector == pvt_pkg::MODE_PROF_VEL) begin
        stateD = pvt_pkg::ST_VEL;
      end else if (operating_mode_selector == pvt_pkg::MODE_PROF_TRQ && closedLoop) begin
        stateD = pvt_pkg::ST_TRQ;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stateQ <= pvt_pkg::ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end
  // ---------------------------------------------------------------
  // velocity ramp generator
  // ---------------------------------------------------------------
  logic signed [31:0] vDem_q;
  logic signed [31:0] vDem_d;
  logic [31:0]        aCur_q;
  logic [31:0]        aCur_d;
  logic [31:0]        velLim;
  logic signed [31:0] tgtRaw;
  logic signed [31:0] tgtClamp;
  logic signed [31:0] velTgt;
  logic signed [31:0] vDiff;
  logic [31:0]        aLim;
  logic [31:0]        aStep;
  logic               jerkMode;
  logic               speedingUp;
  assign velLim   = min32(velCfg.maxProfile, velCfg.maxMotor) & 32'h7fff_ffff;
  assign tgtRaw   = velCfg.polarity[pvt_pkg::POL_VEL_BIT] ? -velCfg.target : velCfg.target;
  assign jerkMode = (velCfg.profileType == pvt_pkg::PROFILE_JERK);
  // clamp target, zero it while halted so the ramp brakes to standstill
  always_comb begin
    tgtClamp = tgtRaw;
    if (tgtRaw > $signed(velLim)) begin
      tgtClamp = $signed(velLim);
    end else if (tgtRaw < -$signed(velLim)) begin
      tgtClamp = -$signed(velLim);
    end
    velTgt = (stateQ == pvt_pkg::ST_VEL && !halt) ? tgtClamp : 32'sh0000_0000;
  end
  always_comb begin
    vDem_d     = vDem_q;
    aCur_d     = aCur_q;
    vDiff      = velTgt - vDem_q;
    speedingUp = (absS(velTgt) > absS(vDem_q)) &&
                 (velTgt[31] == vDem_q[31] || vDem_q == 32'sh0000_0000);
    aLim       = speedingUp ? velCfg.accel : velCfg.decel;
    aStep      = jerkMode ? min32(aCur_q + velCfg.jerk, aLim) : aLim;
    if (aStep == 32'h0000_0000) begin
      aStep = 32'h0000_0001;             // a zero limit must not freeze the axis
    end
    if (stateQ != pvt_pkg::ST_VEL) begin
      vDem_d = 32'sh0000_0000;
      aCur_d = 32'h0000_0000;
    end else if (tick_q) begin
      if (absS(vDiff) <= aStep) begin
        vDem_d = velTgt;
        aCur_d = 32'h0000_0000;
      end else begin
        vDem_d = vDiff[31] ? vDem_q - $signed(aStep) : vDem_q + $signed(aStep);
        aCur_d = jerkMode ? aStep : 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vDem_q <= 32'sh0000_0000;
      aCur_q <= 32'h0000_0000;
    end else begin
      vDem_q <= vDem_d;
      aCur_q <= aCur_d;
    end
  end
  // ---------------------------------------------------------------
  // torque ramp generator
  // ---------------------------------------------------------------
  logic signed [31:0] tDem_q;
  logic signed [31:0] tDem_d;
  logic [31:0]        trqLim;
  logic signed [31:0] trqTgtIn;
  logic signed [31:0] trqTgt;
  logic signed [31:0] tDiff;
  logic [31:0]        tStep;
  // limits in thousandths of rated torque
  assign trqLim   = min32(min32(32'(trqCfg.maxTorque), 32'(trqCfg.maxCurrent)),
                          32'(trqCfg.motorMaxCurrent));
  assign trqTgtIn = 32'(trqCfg.target);
  always_comb begin
    trqTgt = trqTgtIn;
    if (trqTgtIn > $signed(trqLim)) begin
      trqTgt = $signed(trqLim);
    end else if (trqTgtIn < -$signed(trqLim)) begin
      trqTgt = -$signed(trqLim);
    end
    if (stateQ != pvt_pkg::ST_TRQ || halt) begin
      trqTgt = 32'sh0000_0000;
    end
  end
  // slope per second spread over ticks
  always_comb begin
    tDem_d = tDem_q;
    tDiff  = trqTgt - tDem_q;
    tStep  = trqCfg.slope / 32'(pvt_pkg::TICKS_PER_SEC);
    if (tStep == 32'h0000_0000) begin
      tStep = 32'h0000_0001;             // slow slopes still creep forward
    end
    if (stateQ != pvt_pkg::ST_TRQ) begin
      tDem_d = 32'sh0000_0000;
    end else if (tick_q) begin
      if (absS(tDiff) <= tStep) begin
        tDem_d = trqTgt;
      end else begin
        tDem_d = tDiff[31] ? tDem_q - $signed(tStep) : tDem_q + $signed(tStep);
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tDem_q <= 32'sh0000_0000;
    end else begin
      tDem_q <= tDem_d;
    end
  end
  // ---------------------------------------------------------------
  // persistence timers: window, threshold, slippage, torque window
  // ---------------------------------------------------------------
  logic [pvt_pkg::NUM_TIMERS-1:0]                    cond;
  logic [pvt_pkg::NUM_TIMERS-1:0]                    hold;
  logic [pvt_pkg::NUM_TIMERS-1:0][pvt_pkg::TIMER_W-1:0] limT;
  logic [pvt_pkg::NUM_TIMERS-1:0][pvt_pkg::TIMER_W-1:0] cnt_q;
  logic [pvt_pkg::NUM_TIMERS-1:0][pvt_pkg::TIMER_W-1:0] cnt_d;
  always_comb begin
    cond[0] = absS(fb.velActual - velTgt) <= velCfg.window;
    cond[1] = absS(fb.velActual) > velCfg.threshold;
    cond[2] = closedLoop && (absS(fb.slipError) > velCfg.maxSlip);
    cond[3] = absS(32'(fb.trqActual) - trqTgt) <= 32'(trqCfg.window);
    limT[0] = 17'(velCfg.windowTime);
    limT[1] = 17'(velCfg.thresholdTime);
    limT[2] = 17'(velCfg.slipTimeout) + 17'h0_0001;  // strictly longer than timeout
    limT[3] = 17'(trqCfg.windowTime);
  end
  // counters restart whenever the condition drops
  for (genvar i = 0; i < pvt_pkg::NUM_TIMERS; i++) begin : g_timer
    always_comb begin
      cnt_d[i] = cnt_q[i];
      if (!cond[i]) begin
        cnt_d[i] = '0;
      end else if (tick_q && cnt_q[i] != '1) begin
        cnt_d[i] = cnt_q[i] + 17'h0_0001;
      end
      hold[i] = cond[i] && (cnt_q[i] >= limT[i]);
    end
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        cnt_q[i] <= '0;
      end else begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end
  // ---------------------------------------------------------------
  // status word and output registers
  // ---------------------------------------------------------------
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic        capEn_q;
  logic        capEn_d;
  logic        fwEn_q;
  logic        fwEn_d;
  // bits 12 and 13 report in every mode, 10 and 11 per mode
  always_comb begin
    status_d = 16'h0000;
    capEn_d  = 1'b1;
    fwEn_d   = 1'b1;
    status_d[pvt_pkg::ST_ZERO_BIT] = !hold[1];
    status_d[pvt_pkg::ST_DEV_BIT]  = hold[2];
    case (stateQ)
      pvt_pkg::ST_VEL: begin
        status_d[pvt_pkg::ST_TARGET_BIT] = halt ? !hold[1] : hold[0];
      end
      pvt_pkg::ST_TRQ: begin
        status_d[pvt_pkg::ST_TARGET_BIT] = halt ? !hold[1] : hold[3];
        status_d[pvt_pkg::ST_LIMIT_BIT]  = absS(trqTgtIn) > 32'(trqCfg.maxTorque);
        capEn_d = !trqCfg.submode[pvt_pkg::SUBMODE_BIT];
        fwEn_d  = !trqCfg.submode[pvt_pkg::SUBMODE_BIT];
      end
      pvt_pkg::ST_IDLE: status_d[pvt_pkg::ST_TARGET_BIT] = 1'b0;
      default: begin
        status_d = pvt_pkg::STATUS_RESET;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= pvt_pkg::STATUS_RESET;
      capEn_q  <= 1'b1;
      fwEn_q   <= 1'b1;
    end else begin
      status_q <= status_d;
      capEn_q  <= capEn_d;
      fwEn_q   <= fwEn_d;
    end
  end
  assign velDemand    = vDem_q;
  assign velSetpoint  = vDem_q;
  assign torqueDemand = tDem_q;
  assign statusWord   = status_q;
  assign speedCapEn   = capEn_q;
  assign fieldWeakEn  = fwEn_q;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence velTick;
    stateQ == pvt_pkg::ST_VEL && tick_q && stateD == pvt_pkg::ST_VEL;
  endsequence
  sequence trqTick;
    stateQ == pvt_pkg::ST_TRQ && tick_q && stateD == pvt_pkg::ST_TRQ;
  endsequence
  mode_vel_a: assert property (
    opEnabled && operating_mode_selector == pvt_pkg::MODE_PROF_VEL
    |=> stateQ == pvt_pkg::ST_VEL) else $error("velocity mode not entered");
  mode_trq_a: assert property (
    opEnabled && closedLoop && operating_mode_selector == pvt_pkg::MODE_PROF_TRQ
    |=> stateQ == pvt_pkg::ST_TRQ) else $error("torque mode not entered");
  trq_open_loop_a: assert property (
    !closedLoop |=> stateQ != pvt_pkg::ST_TRQ) else $error("torque mode ran in open loop");
  halt_stop_a: assert property (
    velTick and (halt && vDem_q == 32'sh0000_0000) |=> vDem_q == 32'sh0000_0000)
    else $error("motor moved while halted");
  // braking under halt must never grow the demand
  halt_brake_a: assert property (
    velTick and halt |=> absS(vDem_q) <= absS($past(vDem_q)))
    else $error("demand grew while halted");
  vel_target_a: assert property (
    stateQ == pvt_pkg::ST_VEL && !halt |=> statusWord[10] == $past(hold[0]))
    else $error("speed reached bit wrong");
  zero_speed_a: assert property (
    1'b1 |=> statusWord[12] == !$past(hold[1])) else $error("zero speed bit wrong");
  slip_flag_a: assert property (
    !closedLoop |=> !statusWord[13]) else $error("deviation flagged in open loop");
  vel_slope_a: assert property (
    velTick |=> absS(vDem_q - $past(vDem_q)) <=
                ((($past(velCfg.accel) > $past(velCfg.decel)) ?
                  $past(velCfg.accel) : $past(velCfg.decel)) | 32'h0000_0001))
    else $error("speed ramp step too large");
  trq_slope_a: assert property (
    trqTick |=> absS(tDem_q - $past(tDem_q)) <= $past(tStep))
    else $error("torque ramp step too large");
  trq_limit_a: assert property (
    stateQ == pvt_pkg::ST_TRQ && absS(trqTgtIn) > 32'(trqCfg.maxTorque)
    |=> statusWord[11]) else $error("torque limit bit missing");
  trq_cap_a: assert property (
    stateQ == pvt_pkg::ST_TRQ |-> absS(trqTgt) <= trqLim) else $error("torque target above limit");
  submode_a: assert property (
    stateQ == pvt_pkg::ST_TRQ |=> fieldWeakEn == !$past(trqCfg.submode[5]))
    else $error("submode not applied");
endmodule // profile_velocity_torque_modes
`default_nettype wire

// >>> fieldbus_master_model.sv
// fieldbus master model that writes mode code and control word
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reqMode,
  input  wire logic       reqHalt,
  output logic [7:0]      operating_mode_selector,
  output logic [15:0]     ctrlWord
);
  // ---------------------------------------------------------------
  // object writes, one edge after the request
  // ---------------------------------------------------------------
  // mode code writes
  // halt starts set so nothing moves before the first command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      operating_mode_selector <= 8'h00;
      ctrlWord                <= 16'h0100;
    end else begin
      operating_mode_selector <= reqMode;
      ctrlWord                <= {7'h00, reqHalt, 8'h00};
    end
  end
endmodule // fieldbus_master_model
`default_nettype wire

// >>> profile_velocity_torque_modes_test.sv
// self-checking testbench of the profile velocity and torque mode logic
`timescale 1ns/1ns
`default_nettype none
module profile_velocity_torque_modes_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int TC = 4;
  logic               sys_clk;
  logic               rst_n;
  logic [7:0]         reqMode;
  logic               reqHalt;
  logic [7:0]         modeSel;
  logic [15:0]        ctrlWord;
  logic               opEnabled;
  logic               closedLoop;
  pvt_pkg::vel_cfg_t  velCfg;
  pvt_pkg::trq_cfg_t  trqCfg;
  pvt_pkg::feedback_t fb;
  logic [15:0]        statusWord;
  logic signed [31:0] velDemand;
  logic signed [31:0] velSetpoint;
  logic signed [31:0] torqueDemand;
  logic               speedCapEn;
  logic               fieldWeakEn;
  int                 miscompares;
  int                 samplesChecked;
  logic signed [31:0] cap;
  logic signed [31:0] d0;
  logic [15:0]        maxT;
  int                 seed;

  fieldbus_master_model host_u (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .reqMode                (reqMode),
    .reqHalt                (reqHalt),
    .operating_mode_selector(modeSel),
    .ctrlWord               (ctrlWord)
  );

  profile_velocity_torque_modes #(.TICK_CYCLES(TC)) dut_u (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .operating_mode_selector(modeSel),
    .ctrlWord               (ctrlWord),
    .opEnabled              (opEnabled),
    .closedLoop             (closedLoop),
    .velCfg                 (velCfg),
    .trqCfg                 (trqCfg),
    .fb                     (fb),
    .statusWord             (statusWord),
    .velDemand              (velDemand),
    .velSetpoint            (velSetpoint),
    .torqueDemand           (torqueDemand),
    .speedCapEn             (speedCapEn),
    .fieldWeakEn            (fieldWeakEn)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // sample just after the edge so the design's updates have landed
  task automatic waitTicks(input int n);
    repeat (n * TC) @(posedge sys_clk);
    #1;
  endtask

  // bounded wait for a ramp to leave zero, then record its value
  task automatic waitMove(input bit trq);
    for (int i = 0; i < 200 && (trq ? torqueDemand : velDemand) === 32'h0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    d0 = trq ? torqueDemand : velDemand;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] minOf(input logic [31:0] a, input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // the whole sequence needs well under 3000 cycles
  initial begin
    #60000;
    miscompares++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    miscompares = 0;
    samplesChecked = 0;
    rst_n = 1'b0;
    reqMode = 8'h00;
    reqHalt = 1'b0;
    opEnabled = 1'b0;
    closedLoop = 1'b1;
    fb = '0;
    trqCfg = '0;
    velCfg = '0;
    velCfg.window = 32'h5;
    velCfg.windowTime = 16'h3;
    velCfg.threshold = 32'h5;
    velCfg.thresholdTime = 16'h2;
    velCfg.maxSlip = 32'ha;
    velCfg.slipTimeout = 16'h2;
    seed = $urandom(14214);
    repeat (8) @(posedge sys_clk);
    #1;
    check("reset status", statusWord, pvt_pkg::STATUS_RESET);
    check("reset demand", velDemand, 32'h0);
    check("reset cap", speedCapEn, 1'b1);
    $display("reset test done");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    cap = 100 + $urandom % 100;
    d0 = cap + 1 + $urandom % 50;
    // velocity mode, trapezoid ramp, limits drawn at random
    @(posedge sys_clk);
    reqMode <= pvt_pkg::MODE_PROF_VEL;
    opEnabled <= 1'b1;
    velCfg.target <= 32'sh3e8;
    velCfg.accel <= 32'h14;
    velCfg.decel <= 32'h14;
    // the smaller limit lands on either object at random
    if ($urandom % 2) begin
      velCfg.maxProfile <= cap;
      velCfg.maxMotor <= d0;
    end else begin
      velCfg.maxProfile <= d0;
      velCfg.maxMotor <= cap;
    end
    waitMove(1'b0);
    waitTicks(1);
    check("vel step", velDemand - d0, 32'h14);
    check("vel setpoint", velSetpoint, d0 + 32'sh14);
    waitTicks(40);
    check("vel cap", velDemand, minOf(velCfg.maxProfile, velCfg.maxMotor));
    check("not reached", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b0);
    check("zero speed", statusWord[pvt_pkg::ST_ZERO_BIT], 1'b1);
    @(posedge sys_clk);
    fb.velActual <= cap;
    waitTicks(1);
    check("reach early", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b0);
    check("zero early", statusWord[pvt_pkg::ST_ZERO_BIT], 1'b1);
    waitTicks(6);
    check("reached", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b1);
    check("moving", statusWord[pvt_pkg::ST_ZERO_BIT], 1'b0);
    $display("velocity ramp test done");
    // polarity, then halt with the axis still turning
    @(posedge sys_clk);
    velCfg.polarity <= 8'h40;
    waitTicks(30);
    check("vel inverted", velDemand, -cap);
    @(posedge sys_clk);
    reqHalt <= 1'b1;
    waitTicks(3);
    check("braking", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b0);
    waitTicks(30);
    check("halted", velDemand, 32'h0);
    @(posedge sys_clk);
    fb.velActual <= 32'sh0;
    waitTicks(2);
    check("standstill", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b1);
    check("zero again", statusWord[pvt_pkg::ST_ZERO_BIT], 1'b1);
    $display("halt test done");
    // jerk-limited restart after halt release
    @(posedge sys_clk);
    velCfg.polarity <= 8'h00;
    velCfg.profileType <= pvt_pkg::PROFILE_JERK;
    velCfg.jerk <= 32'h4;
    reqHalt <= 1'b0;
    waitMove(1'b0);
    waitTicks(1);
    check("jerk step", (velDemand - d0) < 32'sh14, 1'b1);
    // slippage deviation flag
    @(posedge sys_clk);
    fb.slipError <= 32'sh32;
    waitTicks(1);
    check("slip early", statusWord[pvt_pkg::ST_DEV_BIT], 1'b0);
    waitTicks(6);
    check("slip set", statusWord[pvt_pkg::ST_DEV_BIT], 1'b1);
    @(posedge sys_clk);
    fb.slipError <= 32'sh0;
    reqMode <= 8'h07;
    waitTicks(1);
    check("slip clear", statusWord[pvt_pkg::ST_DEV_BIT], 1'b0);
    check("idle demand", velDemand, 32'h0);
    check("idle reach", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b0);
    $display("jerk and slip test done");
    // torque mode ramp and limits
    maxT = 16'd100 + 16'($urandom % 100);
    @(posedge sys_clk);
    reqMode <= pvt_pkg::MODE_PROF_TRQ;
    trqCfg.target <= 16'sh12c;
    trqCfg.maxTorque <= maxT;
    trqCfg.maxCurrent <= maxT + 16'd50;
    trqCfg.motorMaxCurrent <= 16'h190;
    trqCfg.slope <= 32'hc350;
    trqCfg.window <= 16'h5;
    trqCfg.windowTime <= 16'h2;
    waitMove(1'b1);
    waitTicks(1);
    check("trq step", torqueDemand - d0, 32'h32);
    waitTicks(10);
    check("trq cap", torqueDemand, {16'h0, maxT});
    check("trq limit", statusWord[pvt_pkg::ST_LIMIT_BIT], 1'b1);
    check("speed cap on", speedCapEn, 1'b1);
    @(posedge sys_clk);
    trqCfg.submode <= 32'h20;
    trqCfg.motorMaxCurrent <= 16'h50;
    waitTicks(10);
    check("speed cap off", speedCapEn, 1'b0);
    check("weak off", fieldWeakEn, 1'b0);
    check("motor cap", torqueDemand, 32'h50);
    @(posedge sys_clk);
    trqCfg.target <= 16'sh32;
    fb.trqActual <= 16'sh32;
    waitTicks(1);
    check("limit gone", statusWord[pvt_pkg::ST_LIMIT_BIT], 1'b0);
    check("trq early", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b0);
    waitTicks(6);
    check("trq reached", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b1);
    @(posedge sys_clk);
    reqHalt <= 1'b1;
    waitTicks(6);
    check("trq halted", torqueDemand, 32'h0);
    check("trq still", statusWord[pvt_pkg::ST_TARGET_BIT], 1'b1);
    @(posedge sys_clk);
    reqHalt <= 1'b0;
    waitTicks(6);
    check("trq restart", torqueDemand, 32'h32);
    @(posedge sys_clk);
    closedLoop <= 1'b0;
    waitTicks(1);
    check("open loop", torqueDemand, 32'h0);
    $display("torque test done");
    summarize();
  end
endmodule // profile_velocity_torque_modes_test
`default_nettype wire
